// file: rtl/mcu_port_pkg.sv
package mcu_port_pkg;

    // bus geometry
    localparam int DATA_W      = 18;
    localparam int FIFO_DEPTH  = 16;
    localparam int FIFO_W      = DATA_W + 1;
    localparam int FIFO_RS_BIT = DATA_W;
    localparam int CNT_W       = 8;

    // clock and reference timing, in ns
    localparam int CLK_PERIOD_NS         = 10;
    localparam int REF_CYCLE_PERIOD_NS   = 10;
    localparam int REF_CYCLE_MIN_NS      = 9;
    localparam int REF_CYCLE_MAX_M68_NS  = 155;

    // strobe timing, in reference clock cycles; setup and hold in mclk cycles
    localparam int STROBE_LOW_WIDTH_REF     = 1;
    localparam int STROBE_LOW_MAX_M68_REF   = 100;
    localparam int STROBE_HIGH_WIDTH_REF    = 1;
    localparam int FIRST_READ_DELAY_REF     = 5;
    localparam int SETUP_CYC_INT            = 1;
    localparam int HOLD_CYC_INT             = 1;

    // least time: round up to whole mclk cycles, never below one
    function automatic int ref_to_cycles(input int n_ref);
        int c;
        c = (n_ref * REF_CYCLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // longest time: round down
    function automatic int ref_to_cycles_max(input int n_ref);
        int c;
        c = (n_ref * REF_CYCLE_PERIOD_NS) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [CNT_W-1:0] STROBE_LOW_CYC   = CNT_W'(ref_to_cycles(STROBE_LOW_WIDTH_REF));
    localparam logic [CNT_W-1:0] STROBE_HIGH_CYC  = CNT_W'(ref_to_cycles(STROBE_HIGH_WIDTH_REF));
    localparam logic [CNT_W-1:0] FIRST_READ_CYC   = CNT_W'(ref_to_cycles(FIRST_READ_DELAY_REF));
    localparam logic [CNT_W-1:0] READ_LOW_CYC     = CNT_W'(ref_to_cycles(FIRST_READ_DELAY_REF) + 1);
    localparam logic [CNT_W-1:0] STROBE_MAX_CYC   = CNT_W'(ref_to_cycles_max(STROBE_LOW_MAX_M68_REF));
    localparam logic [CNT_W-1:0] SETUP_CYC        = CNT_W'(SETUP_CYC_INT);
    localparam logic [CNT_W-1:0] HOLD_CYC         = CNT_W'(HOLD_CYC_INT);
    localparam logic [CNT_W-1:0] CNT_ONE          = 8'h01;
    localparam logic [CNT_W-1:0] CNT_ZERO         = 8'h00;

    // register/data select levels
    localparam logic RS_COMMAND = 1'b0;
    localparam logic RS_DATA    = 1'b1;

    // lane masks per transfer width
    localparam logic [DATA_W-1:0] MASK_8  = 18'h000ff;
    localparam logic [DATA_W-1:0] MASK_9  = 18'h001ff;
    localparam logic [DATA_W-1:0] MASK_16 = 18'h0ffff;
    localparam logic [DATA_W-1:0] MASK_18 = 18'h3ffff;
    localparam logic [DATA_W-1:0] DATA_ZERO = 18'h00000;

    typedef enum logic [1:0] {BUS_WIDTH_8, BUS_WIDTH_9, BUS_WIDTH_16, BUS_WIDTH_18} bus_width_t;
    typedef enum logic {MODE_I80, MODE_M68} port_mode_t;

    function automatic logic [DATA_W-1:0] width_mask(input bus_width_t w, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] m;
        case (w)
            BUS_WIDTH_8:  m = MASK_8;
            BUS_WIDTH_9:  m = MASK_9;
            BUS_WIDTH_16: m = MASK_16;
            default:      m = MASK_18;
        endcase
        return d & m;
    endfunction

endpackage

// file: rtl/word_fifo.sv
`timescale 1ns/1ns
module word_fifo
#(
    parameter int WIDTH = 19,
    parameter int DEPTH = 16
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             push;
    logic             pop;

    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // occupancy follows push and pop together
    always_comb
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + 1'b1;
        else if (pop && !push)
            next_count = count - 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count    <= '0;
            in_ready <= 1'b0;
        end
        else
        begin
            count    <= next_count;
            in_ready <= (next_count != FULL_COUNT); // registered so the ready never glitches
        end
    end

    // pointers wrap at depth, so depth need not be a power of two
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == LAST_PTR) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == LAST_PTR) ? '0 : rd_ptr + 1'b1;
        end
    end

    // storage has no reset, only the pointers and the count matter
    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

endmodule // word_fifo

// file: rtl/mcu_parallel_host_port.sv
`timescale 1ns/1ns
module mcu_parallel_host_port
    import mcu_port_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              resetn,
    // write queue: commands and data words
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic              wr_rs,
    input  wire logic [DATA_W-1:0] wr_data,
    // read request, held until rd_done
    input  wire logic              rd_req,
    input  wire logic              rd_rs,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_done,
    // configuration levels, sampled at the start of each access; busy status
    input  wire port_mode_t        mode,
    input  wire logic              m68_cs_strobe,
    input  wire bus_width_t        bus_width,
    output logic                   busy,
    // controller pins
    output logic                   cs_n,
    output logic                   wr_n,
    output logic                   rd_n,
    output logic                   reg_data_select,
    output logic      [DATA_W-1:0] host_data_bus_out,
    input  wire logic [DATA_W-1:0] host_data_bus_in,
    output logic                   host_data_bus_oe_n
);

    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_ACTIVE, ST_RELEASE, ST_GAP} state_t;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // timing sanity on the package constants

    // reference period within its legal window
    localparam bit REF_PERIOD_OK = (REF_CYCLE_PERIOD_NS >= REF_CYCLE_MIN_NS) &&
                                   (REF_CYCLE_PERIOD_NS <= REF_CYCLE_MAX_M68_NS);
    // longest low window stays under the M68 ceiling
    localparam bit LOW_WIDTH_OK  = (READ_LOW_CYC <= STROBE_MAX_CYC) && (STROBE_LOW_CYC <= STROBE_MAX_CYC);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // write queue

    logic              fifo_valid;
    logic              fifo_pop;
    logic [FIFO_W-1:0] fifo_word;

    word_fifo
    #(
        .WIDTH (FIFO_W),
        .DEPTH (FIFO_DEPTH)
    )
    u_wr_fifo
    (
        .clk       (mclk),
        .rst_n     (resetn),
        .in_valid  (wr_valid),
        .in_ready  (wr_ready),
        .in_data   ({wr_rs, wr_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_word)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // access selection and latched attributes

    state_t            state;
    state_t            next_state;
    logic [CNT_W-1:0]  cnt;
    logic              start_write;
    logic              start_read;
    logic              acc_write;
    logic              acc_rs;
    logic [DATA_W-1:0] acc_data;
    port_mode_t        acc_mode;
    logic              acc_cs_strobe;
    bus_width_t        acc_width;
    logic              next_write;
    logic              next_rs;
    logic [DATA_W-1:0] next_data;
    port_mode_t        next_mode;
    logic              next_cs_strobe;
    bus_width_t        next_width;
    logic [CNT_W-1:0]  active_len;
    logic              phase_end;

    // queued writes go first, so a read never overtakes the command that set it up
    assign start_write = (state == ST_IDLE) && fifo_valid && REF_PERIOD_OK && LOW_WIDTH_OK;
    assign start_read  = (state == ST_IDLE) && !fifo_valid && rd_req && REF_PERIOD_OK && LOW_WIDTH_OK;
    assign fifo_pop    = start_write;

    // attributes as they will stand after this edge
    always_comb
    begin
        next_write     = acc_write;
        next_rs        = acc_rs;
        next_data      = acc_data;
        next_mode      = acc_mode;
        next_cs_strobe = acc_cs_strobe;
        next_width     = acc_width;
        if (start_write || start_read)
        begin
            next_write     = start_write;
            next_rs        = start_write ? fifo_word[FIFO_RS_BIT] : rd_rs;
            next_data      = start_write ? width_mask(bus_width, fifo_word[DATA_W-1:0]) : DATA_ZERO;
            next_mode      = mode;
            next_cs_strobe = m68_cs_strobe;
            next_width     = bus_width;
        end
    end

    // mode and width are frozen for the whole access
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_write     <= 1'b0;
            acc_rs        <= RS_COMMAND;
            acc_data      <= DATA_ZERO;
            acc_mode      <= MODE_I80;
            acc_cs_strobe <= 1'b0;
            acc_width     <= BUS_WIDTH_18;
        end
        else
        begin
            acc_write     <= next_write;
            acc_rs        <= next_rs;
            acc_data      <= next_data;
            acc_mode      <= next_mode;
            acc_cs_strobe <= next_cs_strobe;
            acc_width     <= next_width;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // sequencer

    // read window covers first read delay
    assign active_len = acc_write ? STROBE_LOW_CYC : READ_LOW_CYC;

    always_comb
    begin
        case (state)
            ST_SETUP:   phase_end = (cnt == SETUP_CYC - CNT_ONE);
            ST_ACTIVE:  phase_end = (cnt == active_len - CNT_ONE);
            ST_RELEASE: phase_end = (cnt == HOLD_CYC - CNT_ONE);
            ST_GAP:     phase_end = (cnt == STROBE_HIGH_CYC - CNT_ONE);
            default:    phase_end = 1'b1;
        endcase
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (start_write || start_read)
                    next_state = ST_SETUP;
            end
            ST_SETUP:
            begin
                if (phase_end)
                    next_state = ST_ACTIVE;
            end
            ST_ACTIVE:
            begin
                if (phase_end)
                    next_state = ST_RELEASE;
            end
            ST_RELEASE:
            begin
                if (phase_end)
                    next_state = ST_GAP;
            end
            ST_GAP:
            begin
                if (phase_end)
                    next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            state <= ST_IDLE;
        else
            state <= next_state;
    end

    // phase counter restarts on every state change
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            cnt <= CNT_ZERO;
        else if (next_state != state)
            cnt <= CNT_ZERO;
        else
            cnt <= cnt + CNT_ONE;
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // pin drive, registered from the next state so pins change on clean edges

    logic in_frame;
    logic strobe_on;

    assign in_frame  = (next_state == ST_SETUP) || (next_state == ST_ACTIVE) || (next_state == ST_RELEASE);
    assign strobe_on = (next_state == ST_ACTIVE);

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cs_n <= 1'b1;
            wr_n <= 1'b1;
            rd_n <= 1'b1;
        end
        else if (next_mode == MODE_I80)
        begin
            cs_n <= !in_frame;
            wr_n <= !(strobe_on && next_write);
            rd_n <= !(strobe_on && !next_write);
        end
        else if (next_cs_strobe)
        begin
            cs_n <= !strobe_on;
            wr_n <= !in_frame;
            rd_n <= in_frame ? !next_write : 1'b1;
        end
        else
        begin
            cs_n <= !in_frame;
            // enable pulse, latched on its rise
            wr_n <= !strobe_on;
            rd_n <= in_frame ? !next_write : 1'b1;
        end
    end

    // select and write data hold through the release cycle, past the rising strobe
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_data_select    <= RS_COMMAND;
            host_data_bus_out  <= DATA_ZERO;
            host_data_bus_oe_n <= 1'b1;
        end
        else
        begin
            if (in_frame)
                reg_data_select <= next_rs;
            // data stable across the rising edge
            if (in_frame && next_write)
                host_data_bus_out <= next_data;
            host_data_bus_oe_n <= !(in_frame && next_write); // released for reads, no contention
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // read capture and status

    // sampled in the last low cycle; inputs are taken as synchronous to mclk
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_data <= DATA_ZERO;
            rd_done <= 1'b0;
        end
        else
        begin
            rd_done <= 1'b0;
            // sample only after the first read delay
            if ((state == ST_ACTIVE) && phase_end && !acc_write)
            begin
                rd_data <= width_mask(acc_width, host_data_bus_in);
                rd_done <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            busy <= 1'b0;
        else
            busy <= (next_state != ST_IDLE);
    end

endmodule // mcu_parallel_host_port

// file: verif/host_port_chk.sv
`timescale 1ns/1ns
module host_port_chk
    import mcu_port_pkg::*;
(
    input wire logic              mclk,
    input wire logic              resetn,
    input wire logic              rd_done,
    input wire port_mode_t        mode,
    input wire logic              cs_n,
    input wire logic              wr_n,
    input wire logic              rd_n,
    input wire logic              reg_data_select,
    input wire logic [DATA_W-1:0] host_data_bus_out,
    input wire logic              host_data_bus_oe_n
);
    logic [7:0] low_cnt;

    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);

    // length of the m68 active window, both strobes low
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            low_cnt <= 8'h00;
        else if (mode == MODE_M68 && !cs_n && !wr_n)
            low_cnt <= low_cnt + 8'h01;
        else
            low_cnt <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////
    // read strobe low six cycles, then done with it
    sequence s_read_low;
        !rd_n [*6] ##1 rd_n;
    endsequence
    sequence s_write_rise;
        wr_n && $stable(host_data_bus_out) && $stable(reg_data_select);
    endsequence

    chk_write_pulse_one: assert property ((mode == MODE_I80 && $fell(wr_n)) |=> s_write_rise)
        else $error("write strobe not a one cycle pulse with steady data");
    chk_read_first_delay: assert property ((mode == MODE_I80 && $fell(rd_n)) |-> s_read_low ##0 rd_done)
        else $error("read strobe width or done timing wrong");
    chk_read_bus_released: assert property ((mode == MODE_I80 && !rd_n) |-> host_data_bus_oe_n && !cs_n)
        else $error("bus driven or chip deselected during read");
    chk_write_in_frame: assert property ((mode == MODE_I80 && !wr_n) |-> !cs_n && !host_data_bus_oe_n)
        else $error("write strobe outside a selected frame");
    chk_cs_high_gap: assert property ($rose(cs_n) |=> cs_n)
        else $error("chip select gap shorter than needed");
    chk_done_one_cycle: assert property (rd_done |=> !rd_done)
        else $error("read done longer than one cycle");
    chk_m68_dir_drive: assert property ((mode == MODE_M68 && !cs_n) |-> host_data_bus_oe_n == rd_n)
        else $error("bus drive does not follow direction level");
    chk_m68_dir_steady: assert property ((mode == MODE_M68 && !cs_n && !$past(cs_n)) |-> $stable(rd_n))
        else $error("direction level moved inside a frame");
    chk_m68_low_max: assert property (low_cnt <= 8'd100)
        else $error("m68 strobe held low too long");
    chk_m68_strobe_gap: assert property ((mode == MODE_M68 && $rose(wr_n)) |=> wr_n)
        else $error("enable strobe gap shorter than needed");
endmodule // host_port_chk

bind mcu_parallel_host_port host_port_chk u_host_port_chk (.mclk(mclk), .resetn(resetn), .rd_done(rd_done),
    .mode(mode), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n), .reg_data_select(reg_data_select),
    .host_data_bus_out(host_data_bus_out), .host_data_bus_oe_n(host_data_bus_oe_n));

// file: verif/lcd_ctrl_model.sv
`timescale 1ns/1ns
module lcd_ctrl_model
    import mcu_port_pkg::*;
(
    input  wire logic              mclk,
    input  wire port_mode_t        mode,
    input  wire logic              cs_n,
    input  wire logic              wr_n,
    input  wire logic              rd_n,
    input  wire logic              reg_data_select,
    input  wire logic [DATA_W-1:0] host_data_bus_out,
    input  wire logic [DATA_W-1:0] read_word,
    output logic      [DATA_W-1:0] host_data_bus_in
);
    logic [DATA_W-1:0] got_d[$];
    logic              got_rs[$];
    logic              pcs = 1'b1;
    logic              pwr = 1'b1;
    logic              prd = 1'b1;
    logic              prs = 1'b0;
    logic [DATA_W-1:0] pd = 18'h00000;
    logic [DATA_W-1:0] junk = 18'h15a5a;
    logic              rd_act;
    int                rd_cnt = 0;

    assign rd_act = !cs_n && (mode == MODE_I80 ? !rd_n : (rd_n && !wr_n));
    // late first word
    // a released bus toggles, so an early sample never matches by luck
    assign host_data_bus_in = (rd_act && rd_cnt >= 5) ? read_word : junk;

    ////////////////////////////////////////////////////////////////
    // capture on rising strobe
    always @(posedge mclk)
    begin
        junk <= ~junk;
        rd_cnt <= rd_act ? rd_cnt + 1 : 0;
        if ((mode == MODE_I80 && !cs_n && wr_n && !pwr) ||
            (mode == MODE_M68 && !cs_n && !prd && wr_n && !pwr) ||
            (mode == MODE_M68 && cs_n && !pcs && !pwr && !prd))
        begin
            got_d.push_back(pd);
            got_rs.push_back(prs);
        end
        pcs <= cs_n;
        pwr <= wr_n;
        prd <= rd_n;
        prs <= reg_data_select;
        pd  <= host_data_bus_out;
    end
endmodule // lcd_ctrl_model

// file: verif/tb_mcu_parallel_host_port.sv
`timescale 1ns/1ns
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module tb_mcu_parallel_host_port
    import mcu_port_pkg::*;
;
    logic              mclk, resetn, wr_valid, wr_ready, wr_rs, rd_req, rd_rs, rd_done, m68_cs_strobe, busy;
    logic              cs_n, wr_n, rd_n, reg_data_select, host_data_bus_oe_n;
    logic [DATA_W-1:0] wr_data, rd_data, host_data_bus_out, host_data_bus_in, read_word;
    port_mode_t        mode;
    bus_width_t        bus_width;
    int                miscompares = 0;
    int                checks_done = 0;
    logic [DATA_W-1:0] masks [4] = '{MASK_8, MASK_9, MASK_16, MASK_18};

    mcu_parallel_host_port u_mcu_parallel_host_port (.mclk(mclk), .resetn(resetn), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_rs(wr_rs), .wr_data(wr_data), .rd_req(rd_req), .rd_rs(rd_rs),
        .rd_data(rd_data), .rd_done(rd_done), .mode(mode), .m68_cs_strobe(m68_cs_strobe),
        .bus_width(bus_width), .busy(busy), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .reg_data_select(reg_data_select), .host_data_bus_out(host_data_bus_out),
        .host_data_bus_in(host_data_bus_in), .host_data_bus_oe_n(host_data_bus_oe_n));

    lcd_ctrl_model u_lcd_ctrl_model (.mclk(mclk), .mode(mode), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
        .reg_data_select(reg_data_select), .host_data_bus_out(host_data_bus_out),
        .read_word(read_word), .host_data_bus_in(host_data_bus_in));

    ////////////////////////////////////////////////////////////////
    // every task starts and ends 1 ns after a rising edge
    task automatic push(input logic rs, input logic [DATA_W-1:0] d);
        int n;
        wr_valid = 1'b1;
        wr_rs = rs;
        wr_data = d;
        n = 0;
        while (wr_ready !== 1'b1 && n < 100)
        begin
            @(posedge mclk) #1;
            n++;
        end
        @(posedge mclk) #1;
        wr_valid = 1'b0;
        // one idle edge so the next push never raises valid in the same step
        @(posedge mclk) #1;
    endtask

    // the gap between accesses is one idle cycle, so four mean drained
    task automatic settle;
        int n, q;
        n = 0;
        q = 0;
        while (q < 4 && n < 2000)
        begin
            @(posedge mclk) #1;
            n++;
            q = (busy === 1'b0) ? q + 1 : 0;
        end
    endtask

    task automatic take(input logic rs, input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] g;
        logic              r;
        g = u_lcd_ctrl_model.got_d.pop_front();
        r = u_lcd_ctrl_model.got_rs.pop_front();
        `CHECK(r, rs)
        `CHECK(g, d)
    endtask

    task automatic read(input logic rs, input logic [DATA_W-1:0] exp);
        int n;
        rd_req = 1'b1;
        rd_rs = rs;
        n = 0;
        while (rd_done !== 1'b1 && n < 100)
        begin
            @(posedge mclk) #1;
            n++;
        end
        `CHECK(rd_data, exp)
        `CHECK(reg_data_select, rs)
        rd_req = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////
    // command, data and read at every width in one protocol
    task automatic t_widths(input port_mode_t m, input logic cs_s);
        int w;
        mode = m;
        m68_cs_strobe = cs_s;
        for (w = 0; w < 4; w++)
        begin
            bus_width = bus_width_t'(w);
            read_word = 18'h1b4c6 ^ 18'(w);
            push(RS_COMMAND, 18'h2c3a5);
            push(RS_DATA, 18'h3d1e7);
            settle;
            take(RS_COMMAND, 18'h2c3a5 & masks[w]);
            take(RS_DATA, 18'h3d1e7 & masks[w]);
            read(w[0], (18'h1b4c6 ^ 18'(w)) & masks[w]);
            settle;
        end
        $display("widths test done: mode %0d cs strobe %0d", m, cs_s);
    endtask

    // fill the queue back to back until it refuses, then drain in order
    task automatic t_fill;
        int n, k;
        mode = MODE_I80;
        bus_width = BUS_WIDTH_18;
        wr_rs = RS_DATA;
        wr_valid = 1'b1;
        k = 0;
        n = 0;
        while (wr_ready === 1'b1 && n < 100)
        begin
            wr_data = 18'h01000 + 18'(k);
            @(posedge mclk) #1;
            k++;
            n++;
        end
        wr_data = 18'h01000 + 18'(k);
        `CHECK(wr_ready, 1'b0)
        @(posedge mclk) #1;
        wr_valid = 1'b0;
        settle;
        `CHECK(u_lcd_ctrl_model.got_d.size(), k)
        for (n = 0; n < k; n++)
            take(RS_DATA, 18'h01000 + 18'(n));
        $display("fill test done: %0d words", k);
    endtask

    task automatic stop_test;
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // watchdog: the whole sequence needs about four hundred fifty cycles
    initial
    begin
        #200000;
        miscompares++;
        stop_test;
    end

    initial
    begin
        time t0;
        resetn = 1'b0;
        wr_valid = 1'b0;
        wr_rs = 1'b0;
        wr_data = 18'h00000;
        rd_req = 1'b0;
        rd_rs = 1'b0;
        mode = MODE_I80;
        m68_cs_strobe = 1'b0;
        bus_width = BUS_WIDTH_18;
        read_word = 18'h00000;
        repeat (5) @(posedge mclk);
        #1 resetn = 1'b1;
        `CHECK({cs_n, wr_n, rd_n, host_data_bus_oe_n, busy}, 5'b11110)
        // the reference clock is mclk itself, so its period must sit in the legal window
        t0 = $time;
        @(posedge mclk) #1;
        `CHECK((($time - t0) >= REF_CYCLE_MIN_NS) && (($time - t0) <= REF_CYCLE_MAX_M68_NS), 1'b1)
        $display("reset test done");
        t_widths(MODE_I80, 1'b0);
        t_widths(MODE_M68, 1'b0);
        t_widths(MODE_M68, 1'b1);
        t_fill;
        stop_test;
    end
endmodule // tb_mcu_parallel_host_port
